//--- eps_checker.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module eps_checker #(
  parameter int STAGES = 4,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [STAGES-1:0] alarm_input,
  input wire logic [STAGES-1:0] trip_input,
  input wire logic [STAGES-1:0] alarm_output,
  input wire logic [STAGES-1:0] trip_output,
  input wire logic [STAGES-1:0] trip_command_output,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  a_command_needs_trip:
    assert property ((trip_command_output & ~trip_output) == '0)
      else $error("command without trip");
  a_alarm_needs_input:
    assert property ((alarm_output & ~$past(alarm_input, 3)) == '0)
      else $error("alarm without input");
  a_trip_needs_input:
    assert property ((trip_output & ~$past(trip_input, 3)) == '0)
      else $error("trip without input");
  a_write_answered:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
  a_read_answered:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
  a_bresp_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
  a_rdata_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
  a_write_refused:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken early");
  a_read_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken early");
endmodule

bind eps_top eps_checker #(.STAGES(STAGES), .ADDR_W(ADDR_W)) i_chk (.*);

//--- eps_ext_model.sv
`timescale 1ns/1ps
// ----
// contact levels of the outside facilities
// ----
module eps_ext_model (
  input wire logic [3:0] cmd_a,
  input wire logic [3:0] cmd_b,
  input wire logic [3:0] cmd_tc,
  input wire logic [3:0] cmd_al,
  input wire logic [3:0] cmd_tr,
  output logic [3:0] external_block_input_a,
  output logic [3:0] external_block_input_b,
  output logic [3:0] external_trip_command_block_input,
  output logic [3:0] alarm_input,
  output logic [3:0] trip_input
);
  assign external_block_input_a = cmd_a;
  assign external_block_input_b = cmd_b;
  assign external_trip_command_block_input = cmd_tc;
  assign alarm_input = cmd_al;
  assign trip_input = cmd_tr;
endmodule

//--- eps_map.svh
`ifndef EPS_MAP_SVH
`define EPS_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EPS_OFF_PLAN 8'h00
`define EPS_OFF_FUNC 8'h04
`define EPS_OFF_BLK_EN 8'h08
`define EPS_OFF_TCB_EN 8'h0C
`define EPS_OFF_PERM_TCB 8'h10
`define EPS_OFF_ASSIGN 8'h14
`define EPS_OFF_IN_STATE 8'h18
`define EPS_OFF_FLAGS 8'h1C
`define EPS_OFF_IRQ_STAT 8'h20
`define EPS_OFF_IRQ_MASK 8'h24

// ---------------------------------------------------------------
// layout
// ---------------------------------------------------------------
`define EPS_LANE 8
`define EPS_LANES 4
`define EPS_MAX_STAGES 4
`define EPS_IN_BLK_A 0
`define EPS_IN_BLK_B 1
`define EPS_IN_TCB 2
`define EPS_IN_ALARM 3
`define EPS_IN_TRIP 4
`define EPS_FL_ACTIVE 0
`define EPS_FL_EXT_BLK 1
`define EPS_FL_TC_BLK 2
`define EPS_FL_TC_EXT_BLK 3
`define EPS_FL_ALARM 4
`define EPS_FL_TRIP 5
`define EPS_FL_TCMD 6
`define EPS_IRQ_TRIP_BASE 4

// ---------------------------------------------------------------
// reset values and responses
// ---------------------------------------------------------------
`define EPS_RST_WORD 32'h0000_0000
`define EPS_RESP_OKAY 2'h0
`define EPS_RESP_SLVERR 2'h2

`endif

//--- eps_pkg.sv
package eps_pkg;
  typedef logic [31:0] eps_word_t;
  typedef logic [3:0] eps_strb_t;
  typedef logic [1:0] eps_resp_t;
endpackage

//--- eps_top.sv
// Summary of operation
// - four identical independent external protection stages
// - per-stage planning used/unused; unused stage gives no alarm, trip, command
// - two assignable block inputs; either blocks stage when enabled
// - assignable input suppresses only trip command when its enable is set
// - alarm output follows assigned external alarm input
// - trip output follows assigned external trip input
// - function setting activates stage; inactive stage gives no outputs
// - block enable acts only when a block signal is assigned
// - asserted block signal blocks only if its matching enable is active
// - permanent trip command block suppresses command regardless of inputs
// - readable input states mirror assigned block, alarm and trip inputs
// - flags: active, ext blocked, command blocked, ext command blocked, alarm, trip, command
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "eps_map.svh"

module eps_top #(
  parameter int STAGES = 4,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [STAGES-1:0] external_block_input_a,
  input wire logic [STAGES-1:0] external_block_input_b,
  input wire logic [STAGES-1:0] external_trip_command_block_input,
  input wire logic [STAGES-1:0] alarm_input,
  input wire logic [STAGES-1:0] trip_input,
  output logic [STAGES-1:0] alarm_output,
  output logic [STAGES-1:0] trip_output,
  output logic [STAGES-1:0] trip_command_output,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  initial begin
    if (STAGES < 1 || STAGES > `EPS_MAX_STAGES || ADDR_W < 6 || ADDR_W > 32) begin
      $error("eps_top: unsupported STAGES or ADDR_W");
    end
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic eps_pkg::eps_word_t merge(input eps_pkg::eps_word_t old,
                                               input eps_pkg::eps_word_t data,
                                               input eps_pkg::eps_strb_t strb);
    eps_pkg::eps_word_t res;
    res = old;
    for (int i = 0; i < `EPS_LANES; i++) begin
      if (strb[i]) begin
        res[i*`EPS_LANE +: `EPS_LANE] = data[i*`EPS_LANE +: `EPS_LANE];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] low_addr(input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'(a);
    return {w[7:2], 2'h0};
  endfunction

  function automatic eps_pkg::eps_word_t widen(input logic [STAGES-1:0] v);
    return 32'(v);
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [STAGES-1:0] blk_a_m_r, blk_b_m_r, tcb_m_r, alm_m_r, trp_m_r;
  logic [STAGES-1:0] blk_a_s_r, blk_b_s_r, tcb_s_r, alm_s_r, trp_s_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blk_a_m_r <= '0;
      blk_b_m_r <= '0;
      tcb_m_r <= '0;
      alm_m_r <= '0;
      trp_m_r <= '0;
      blk_a_s_r <= '0;
      blk_b_s_r <= '0;
      tcb_s_r <= '0;
      alm_s_r <= '0;
      trp_s_r <= '0;
    end else begin
      blk_a_m_r <= external_block_input_a;
      blk_b_m_r <= external_block_input_b;
      tcb_m_r <= external_trip_command_block_input;
      alm_m_r <= alarm_input;
      trp_m_r <= trip_input;
      blk_a_s_r <= blk_a_m_r;
      blk_b_s_r <= blk_b_m_r;
      tcb_s_r <= tcb_m_r;
      alm_s_r <= alm_m_r;
      trp_s_r <= trp_m_r;
    end
  end

  // ---------------------------------------------------------------
  // settings and register bus
  // ---------------------------------------------------------------
  logic [STAGES-1:0] plan_r, plan_nxt, func_r, func_nxt;
  logic [STAGES-1:0] blk_en_r, blk_en_nxt, tcb_en_r, tcb_en_nxt;
  logic [STAGES-1:0] perm_r, perm_nxt;
  eps_pkg::eps_word_t assign_r, assign_nxt, in_state_r, in_state_nxt;
  eps_pkg::eps_word_t flags_r, flags_nxt, mask_r, mask_nxt;
  eps_pkg::eps_word_t irq_stat_r, irq_stat_nxt, rdata_r, rdata_nxt, rd_word;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  eps_pkg::eps_word_t w_data_r, w_data_nxt;
  eps_pkg::eps_strb_t w_strb_r, w_strb_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  eps_pkg::eps_resp_t bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rd_hit, rd_stat_clr, do_write;
  eps_pkg::eps_word_t irq_events;
  logic irq_r, irq_nxt;
  logic [STAGES-1:0] alarm_r, alarm_nxt, trip_r, trip_nxt, tcmd_r, tcmd_nxt;

  always_comb begin
    rd_hit = 1'b1;
    unique case (low_addr(s_axi_araddr))
      `EPS_OFF_PLAN: rd_word = widen(plan_r);
      `EPS_OFF_FUNC: rd_word = widen(func_r);
      `EPS_OFF_BLK_EN: rd_word = widen(blk_en_r);
      `EPS_OFF_TCB_EN: rd_word = widen(tcb_en_r);
      `EPS_OFF_PERM_TCB: rd_word = widen(perm_r);
      `EPS_OFF_ASSIGN: rd_word = assign_r;
      `EPS_OFF_IN_STATE: rd_word = in_state_r;
      `EPS_OFF_FLAGS: rd_word = flags_r;
      `EPS_OFF_IRQ_STAT: rd_word = irq_stat_r;
      `EPS_OFF_IRQ_MASK: rd_word = mask_r;
      default: begin
        rd_word = `EPS_RST_WORD;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    plan_nxt = plan_r;
    func_nxt = func_r;
    blk_en_nxt = blk_en_r;
    tcb_en_nxt = tcb_en_r;
    perm_nxt = perm_r;
    assign_nxt = assign_r;
    mask_nxt = mask_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    rd_stat_clr = 1'b0;
    do_write = aw_have_r && w_have_r && !bvalid_r;
    if (s_axi_awvalid && awready_r) begin
      aw_addr_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
      w_have_nxt = 1'b1;
      wready_nxt = 1'b0;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `EPS_RESP_OKAY;
      unique case (low_addr(aw_addr_r))
        `EPS_OFF_PLAN: plan_nxt = STAGES'(merge(widen(plan_r), w_data_r, w_strb_r));
        `EPS_OFF_FUNC: func_nxt = STAGES'(merge(widen(func_r), w_data_r, w_strb_r));
        `EPS_OFF_BLK_EN: blk_en_nxt = STAGES'(merge(widen(blk_en_r), w_data_r, w_strb_r));
        `EPS_OFF_TCB_EN: tcb_en_nxt = STAGES'(merge(widen(tcb_en_r), w_data_r, w_strb_r));
        `EPS_OFF_PERM_TCB: perm_nxt = STAGES'(merge(widen(perm_r), w_data_r, w_strb_r));
        `EPS_OFF_ASSIGN: assign_nxt = merge(assign_r, w_data_r, w_strb_r);
        `EPS_OFF_IRQ_MASK: mask_nxt = merge(mask_r, w_data_r, w_strb_r);
        `EPS_OFF_IN_STATE, `EPS_OFF_FLAGS, `EPS_OFF_IRQ_STAT: bresp_nxt = `EPS_RESP_OKAY;
        default: bresp_nxt = `EPS_RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = rd_hit ? `EPS_RESP_OKAY : `EPS_RESP_SLVERR;
      rd_stat_clr = (low_addr(s_axi_araddr) == `EPS_OFF_IRQ_STAT);
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      plan_r <= '0;
      func_r <= '0;
      blk_en_r <= '0;
      tcb_en_r <= '0;
      perm_r <= '0;
      assign_r <= `EPS_RST_WORD;
      mask_r <= `EPS_RST_WORD;
      aw_addr_r <= '0;
      w_data_r <= `EPS_RST_WORD;
      w_strb_r <= '0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `EPS_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `EPS_RESP_OKAY;
      rdata_r <= `EPS_RST_WORD;
    end else begin
      plan_r <= plan_nxt;
      func_r <= func_nxt;
      blk_en_r <= blk_en_nxt;
      tcb_en_r <= tcb_en_nxt;
      perm_r <= perm_nxt;
      assign_r <= assign_nxt;
      mask_r <= mask_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // protection stages
  // ---------------------------------------------------------------
  always_comb begin
    logic [`EPS_LANE-1:0] asg, lvl;
    logic blocked, act, tc_ext;
    asg = '0;
    lvl = '0;
    blocked = 1'b0;
    act = 1'b0;
    tc_ext = 1'b0;
    in_state_nxt = `EPS_RST_WORD;
    flags_nxt = `EPS_RST_WORD;
    alarm_nxt = '0;
    trip_nxt = '0;
    tcmd_nxt = '0;
    for (int s = 0; s < STAGES; s++) begin
      asg = assign_r[s*`EPS_LANE +: `EPS_LANE];
      lvl = '0;
      lvl[`EPS_IN_BLK_A] = blk_a_s_r[s];
      lvl[`EPS_IN_BLK_B] = blk_b_s_r[s];
      lvl[`EPS_IN_TCB] = tcb_s_r[s];
      lvl[`EPS_IN_ALARM] = alm_s_r[s];
      lvl[`EPS_IN_TRIP] = trp_s_r[s];
      lvl = lvl & asg;
      in_state_nxt[s*`EPS_LANE +: `EPS_LANE] = lvl;
      blocked = blk_en_r[s] && (lvl[`EPS_IN_BLK_A] || lvl[`EPS_IN_BLK_B]);
      act = plan_r[s] && func_r[s] && !blocked;
      tc_ext = tcb_en_r[s] && lvl[`EPS_IN_TCB];
      alarm_nxt[s] = act && lvl[`EPS_IN_ALARM];
      trip_nxt[s] = act && lvl[`EPS_IN_TRIP];
      tcmd_nxt[s] = trip_nxt[s] && !perm_r[s] && !tc_ext;
      flags_nxt[s*`EPS_LANE + `EPS_FL_ACTIVE] = act;
      flags_nxt[s*`EPS_LANE + `EPS_FL_EXT_BLK] = blocked;
      flags_nxt[s*`EPS_LANE + `EPS_FL_TC_BLK] = perm_r[s];
      flags_nxt[s*`EPS_LANE + `EPS_FL_TC_EXT_BLK] = tc_ext;
      flags_nxt[s*`EPS_LANE + `EPS_FL_ALARM] = alarm_nxt[s];
      flags_nxt[s*`EPS_LANE + `EPS_FL_TRIP] = trip_nxt[s];
      flags_nxt[s*`EPS_LANE + `EPS_FL_TCMD] = tcmd_nxt[s];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_state_r <= `EPS_RST_WORD;
      flags_r <= `EPS_RST_WORD;
      alarm_r <= '0;
      trip_r <= '0;
      tcmd_r <= '0;
    end else begin
      in_state_r <= in_state_nxt;
      flags_r <= flags_nxt;
      alarm_r <= alarm_nxt;
      trip_r <= trip_nxt;
      tcmd_r <= tcmd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_comb begin
    irq_events = `EPS_RST_WORD;
    irq_events[STAGES-1:0] = alarm_nxt & ~alarm_r;
    irq_events[`EPS_IRQ_TRIP_BASE +: STAGES] = trip_nxt & ~trip_r;
    irq_stat_nxt = (rd_stat_clr ? `EPS_RST_WORD : irq_stat_r) | irq_events;
    irq_nxt = |(irq_stat_nxt & mask_r);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_r <= `EPS_RST_WORD;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign alarm_output = alarm_r;
  assign trip_output = trip_r;
  assign trip_command_output = tcmd_r;
  assign irq = irq_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

endmodule

//--- tb.sv
`timescale 1ns/1ps
`include "eps_map.svh"
module tb;
  // ----
  // signals
  // ----
  logic clock;
  logic rst;
  logic irq;
  logic [3:0] cmd_a, cmd_b, cmd_tc, cmd_al, cmd_tr, pl, fu, bk, tcb, pm;
  logic [3:0] external_block_input_a, external_block_input_b, external_trip_command_block_input;
  logic [3:0] alarm_input, trip_input, alarm_output, trip_output, trip_command_output;
  logic [7:0] s_axi_awaddr, s_axi_araddr, asg;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  eps_pkg::eps_word_t rd_d;
  eps_pkg::eps_resp_t rd_r;
  int bad_count;
  int checks_done;

  eps_top #(.STAGES(4), .ADDR_W(8)) i_dut (.*);
  eps_ext_model i_ext (.*);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input eps_pkg::eps_word_t d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    rd_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) bad_count++;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) bad_count++;
  endtask

  // case: plan, function, block en, command block en, permanent, levels a b tc al tr, assign
  task automatic run_case(input logic [47:0] c);
    logic [7:0] v;
    logic [31:0] ef, ei;
    logic [3:0] eal, etr, ecm;
    logic blk, act;
    {pl, fu, bk, tcb, pm} = c[47:28];
    asg = c[7:0];
    wr(`EPS_OFF_PLAN, {28'h0, pl});
    wr(`EPS_OFF_FUNC, {28'h0, fu});
    wr(`EPS_OFF_BLK_EN, {28'h0, bk});
    wr(`EPS_OFF_TCB_EN, {28'h0, tcb});
    wr(`EPS_OFF_PERM_TCB, {28'h0, pm});
    wr(`EPS_OFF_ASSIGN, {4{asg}});
    {cmd_a, cmd_b, cmd_tc, cmd_al, cmd_tr} <= c[27:8];
    hold(8);
    for (int s = 0; s < 4; s++) begin
      v = {3'h0, cmd_tr[s], cmd_al[s], cmd_tc[s], cmd_b[s], cmd_a[s]} & asg;
      blk = bk[s] & (v[0] | v[1]);
      act = pl[s] & fu[s] & !blk;
      eal[s] = act & v[3];
      etr[s] = act & v[4];
      ecm[s] = etr[s] & !pm[s] & !(tcb[s] & v[2]);
      ei[8*s +: 8] = v;
      ef[8*s +: 8] = {1'b0, ecm[s], etr[s], eal[s], tcb[s] & v[2], pm[s], blk, act};
    end
    check(alarm_output, eal, "alarm output");
    check(trip_output, etr, "trip output");
    check(trip_command_output, ecm, "command output");
    rd(`EPS_OFF_FLAGS);
    check(rd_d, ef, "flags");
    rd(`EPS_OFF_IN_STATE);
    check(rd_d, ei, "input states");
  endtask

  // ----
  // sequence
  // ----
  initial begin
    rst = 1'b1;
    bad_count = 0;
    checks_done = 0;
    {cmd_a, cmd_b, cmd_tc, cmd_al, cmd_tr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int o = 0; o <= 36; o += 4) begin
      rd(o[7:0]);
      check(rd_d, `EPS_RST_WORD, "reset value");
    end
    run_case(48'h0F000_000FF_1F);
    run_case(48'hF0000_000FF_1F);
    run_case(48'hFF000_000FF_1F);
    rd(`EPS_OFF_IRQ_STAT);
    check(rd_d, 32'h0000_00FF, "event status");
    rd(`EPS_OFF_IRQ_STAT);
    check(rd_d, 32'h0, "status after read");
    wr(`EPS_OFF_IRQ_MASK, 32'h0000_000F);
    cmd_tr <= 4'h0;
    hold(8);
    cmd_tr <= 4'hF;
    hold(8);
    check(irq, 1'b0, "masked irq");
    wr(`EPS_OFF_IRQ_MASK, 32'h0000_00FF);
    hold(3);
    check(irq, 1'b1, "unmasked irq");
    rd(`EPS_OFF_IRQ_STAT);
    check(rd_d, 32'h0000_00F0, "trip events");
    hold(3);
    check(irq, 1'b0, "cleared irq");
    run_case(48'hFF005_000FF_1F);
    run_case(48'hFF030_006FF_1F);
    run_case(48'hFFC00_580FF_1F);
    run_case(48'hFFC30_586FF_18);
    run_case(48'hFF000_000FF_10);
    run_case(48'h5F000_000FF_1F);
    wr(`EPS_OFF_FLAGS, 32'hFFFF_FFFF);
    check(rd_r, `EPS_RESP_OKAY, "read-only write");
    rd(`EPS_OFF_FLAGS);
    check(rd_d, 32'h0071_0071, "flags kept");
    wr(8'h40, 32'h0000_0001);
    check(rd_r, `EPS_RESP_SLVERR, "unmapped write");
    rd(8'h40);
    check(rd_r, `EPS_RESP_SLVERR, "unmapped read");
    check(rd_d, 32'h0, "unmapped data");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    final_report();
  end
endmodule
